// file: design/mcf_core.v
// Eight-bit microcontroller core: pipeline, program counter, stack, data plane and ALU.
`timescale 1ns/1ps
`include "mcf_defs.vh"
// What this block does
// - Each instruction cycle spans two clocks, phase one then phase two.
// - PC updates entering phase one; the word is latched at phase two end.
// - A fetched word executes in the next cycle while the next one is fetched.
// - Branches take two cycles; the already-fetched word is discarded.
// - Copy W into a write-only plane register, direct address only.
// - Low file addresses are special registers, the rest general RAM.
// - The indirect location accesses the file register named by the pointer.
// - Bit set, clear and test work only in the lower half of the plane.
// - The PC is 12 bits, addressing 4096 words of 14 bits.
// - Otherwise the PC advances by one after each instruction.
// - Reset loads PC with 000h; interrupt entry loads 001h.
// - Call and jump load all 12 PC bits from the instruction.
// - Return instructions restore the PC from the stack top.
// - Other PC writes change only the low eight bits.
// - The return stack holds six entries of 12 bits.
// - Calls and interrupt entry push; every return pops one entry.
// - The ALU handles 8-bit add, subtract, shift and logic.
// - Two-operand ops use W and a file register or a literal.
// - Single-operand ops act on W or a file register.
// - The ALU updates carry, digit carry and zero flags per instruction.
// - Subtraction carry and digit carry are inverted borrows.
// - Flag bits are not written when a flag-setting op targets status.
// - Addition digit carry is set on a carry out of the low nibble.
// - Pending enabled interrupts enter at cycle end via call 001.
// - The interrupt flag clears one instruction after interrupt return.
module mcf_core #(
    parameter STACK_DEPTH = 6,
    parameter SP_W        = 3
) (
    input  wire        ref_clk,
    input  wire        nrst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg  [11:0] rom_addr,
    input  wire [13:0] rom_data,
    input  wire        irq,
    output reg         phase_two,
    output reg         wplane_wr,
    output reg  [5:0]  wplane_addr,
    output reg  [7:0]  wplane_data
);

////////////////////////////////////////////////////////////////////////////////
// State.
reg  [13:0]     ir_reg;
reg             flush_reg;
reg  [7:0]      w_reg;
reg  [7:0]      status_reg;
reg  [7:0]      pointer_reg;
reg             iflag_reg;
reg             iclr_reg;
reg  [SP_W-1:0] sp_reg;
reg  [1:0]      ctrl_reg;
reg  [11:0]     stack_mem [0:STACK_DEPTH-1];
reg  [7:0]      ram_mem [0:63];

// Decode and datapath results.
reg             step;
reg             exec;
reg  [1:0]      cls;
reg  [5:0]      fadr;
reg  [5:0]      ea;
reg  [7:0]      fval;
reg  [7:0]      lit;
reg             is_lit;
reg             sub_sel;
reg  [7:0]      add_a;
reg  [7:0]      add_b;
reg  [8:0]      sum;
reg  [4:0]      nib;
reg  [7:0]      res;
reg  [7:0]      bmask;
reg             wr_w;
reg             wr_f;
reg             data_op;
reg             z_en;
reg             c_en;
reg             dig_en;
reg             c_val;
reg             push;
reg             pop;
reg             jump;
reg             skip;
reg             iret;
reg             wpl;
reg             take;
reg  [11:0]     tgt;
reg  [SP_W-1:0] sp_top;
reg  [SP_W-1:0] sp_inc;
reg  [7:0]      st_next;
reg  [7:0]      keep_mask;
reg             apb_wr;

////////////////////////////////////////////////////////////////////////////////
// Combinational decode, operand fetch, ALU and next-PC selection.
always @* begin
    step = ctrl_reg[`MCF_CTRL_RUN] & (phase_two == `MCF_PHASE_TWO);
    exec = step & ~flush_reg;
    cls  = ir_reg[`MCF_CLS];
    fadr = ir_reg[`MCF_FADDR];
    lit  = ir_reg[`MCF_LIT];
    ea   = (fadr == `MCF_A_INDIRECT) ? pointer_reg[5:0] : fadr;
    case (ea)
        `MCF_A_INDIRECT: fval = 8'h00;
        `MCF_A_PCLOW:    fval = rom_addr[7:0];
        `MCF_A_STATUS:   fval = status_reg;
        `MCF_A_POINTER:  fval = pointer_reg;
        default:         fval = (ea >= `MCF_A_RAM_BASE) ? ram_mem[ea] : 8'h00;
    endcase
    is_lit  = (cls == `MCF_CLS_BITLIT) & ir_reg[`MCF_SUBSEL];
    // subtract adds inverted W plus one
    sub_sel = ((cls == `MCF_CLS_BYTE) & (ir_reg[`MCF_BOP] == `MCF_OP_SUB))
            | (is_lit & (ir_reg[`MCF_LOP] == `MCF_LOP_SUBLW));
    add_a   = is_lit ? lit : fval;
    add_b   = sub_sel ? ~w_reg : w_reg;
    sum     = {1'b0, add_a} + {1'b0, add_b} + {8'h00, sub_sel};
    nib     = {1'b0, add_a[3:0]} + {1'b0, add_b[3:0]} + {4'h0, sub_sel};
    bmask   = 8'h01 << ir_reg[`MCF_BITNUM];
    res     = 8'h00;
    wr_w    = 1'b0;
    wr_f    = 1'b0;
    data_op = 1'b0;
    z_en    = 1'b0;
    c_en    = 1'b0;
    dig_en  = 1'b0;
    c_val   = sum[8];
    push    = 1'b0;
    pop     = 1'b0;
    jump    = 1'b0;
    skip    = 1'b0;
    iret    = 1'b0;
    wpl     = 1'b0;
    tgt     = rom_addr + `MCF_PC_STEP;
    if (exec) begin
        case (cls)
            `MCF_CLS_BYTE: begin
                if (!ir_reg[`MCF_SUBSEL]) begin
                    data_op = 1'b1;
                    case (ir_reg[`MCF_BOP])
                        `MCF_OP_MISC: begin
                            data_op = 1'b0;
                            res     = w_reg;
                            wr_f    = ir_reg[`MCF_DBIT];
                            if (!ir_reg[`MCF_DBIT] && fadr == `MCF_MISC_RET) begin
                                pop = 1'b1;
                            end
                            if (!ir_reg[`MCF_DBIT] && fadr == `MCF_MISC_IRET) begin
                                pop  = 1'b1;
                                iret = 1'b1;
                            end
                        end
                        `MCF_OP_CLR: begin
                            res  = 8'h00;
                            z_en = 1'b1;
                        end
                        `MCF_OP_SUB, `MCF_OP_ADD: begin
                            res    = sum[7:0];
                            z_en   = 1'b1;
                            c_en   = 1'b1;
                            dig_en = 1'b1;
                        end
                        `MCF_OP_DEC: begin
                            res  = fval - 8'h01;
                            z_en = 1'b1;
                        end
                        `MCF_OP_IOR: begin
                            res  = fval | w_reg;
                            z_en = 1'b1;
                        end
                        `MCF_OP_AND: begin
                            res  = fval & w_reg;
                            z_en = 1'b1;
                        end
                        `MCF_OP_XOR: begin
                            res  = fval ^ w_reg;
                            z_en = 1'b1;
                        end
                        `MCF_OP_MOV: begin
                            res  = fval;
                            z_en = 1'b1;
                        end
                        `MCF_OP_COM: begin
                            res  = ~fval;
                            z_en = 1'b1;
                        end
                        `MCF_OP_INC: begin
                            res  = fval + 8'h01;
                            z_en = 1'b1;
                        end
                        `MCF_OP_RRF: begin
                            res   = {status_reg[`MCF_ST_C], fval[7:1]};
                            c_val = fval[0];
                            c_en  = 1'b1;
                        end
                        `MCF_OP_RLF: begin
                            res   = {fval[6:0], status_reg[`MCF_ST_C]};
                            c_val = fval[7];
                            c_en  = 1'b1;
                        end
                        `MCF_OP_SWAP: begin
                            res = {fval[3:0], fval[7:4]};
                        end
                        `MCF_OP_WPLANE: begin
                            data_op = 1'b0;
                            wpl     = 1'b1;
                        end
                        default: data_op = 1'b0;
                    endcase
                    wr_w = data_op & ~ir_reg[`MCF_DBIT];
                    wr_f = wr_f | (data_op & ir_reg[`MCF_DBIT]);
                end
            end
            `MCF_CLS_BITLIT: begin
                if (is_lit) begin
                    wr_w = 1'b1;
                    case (ir_reg[`MCF_LOP])
                        `MCF_LOP_MOVLW: res = lit;
                        `MCF_LOP_RETVAL: begin
                            res = lit;
                            pop = 1'b1;
                        end
                        `MCF_LOP_IORLW: begin
                            res  = lit | w_reg;
                            z_en = 1'b1;
                        end
                        `MCF_LOP_ANDLW: begin
                            res  = lit & w_reg;
                            z_en = 1'b1;
                        end
                        `MCF_LOP_XORLW: begin
                            res  = lit ^ w_reg;
                            z_en = 1'b1;
                        end
                        `MCF_LOP_ADDLW, `MCF_LOP_SUBLW: begin
                            res    = sum[7:0];
                            z_en   = 1'b1;
                            c_en   = 1'b1;
                            dig_en = 1'b1;
                        end
                        default: begin
                            wr_w = 1'b0;
                            pop  = 1'b1;
                        end
                    endcase
                end else if (!ea[`MCF_HALF_BIT]) begin
                    // bit access in lower half only
                    case (ir_reg[`MCF_BITOP])
                        `MCF_BIT_CLR: begin
                            res  = fval & ~bmask;
                            wr_f = 1'b1;
                        end
                        `MCF_BIT_SET: begin
                            res  = fval | bmask;
                            wr_f = 1'b1;
                        end
                        `MCF_BIT_TSTC: skip = ((fval & bmask) == 8'h00);
                        default:       skip = ((fval & bmask) != 8'h00);
                    endcase
                end
            end
            `MCF_CLS_CALL: begin
                push = 1'b1;
                jump = 1'b1;
                tgt  = ir_reg[`MCF_TARGET];
            end
            default: begin
                jump = 1'b1;
                tgt  = ir_reg[`MCF_TARGET];
            end
        endcase
    end
    sp_top = (sp_reg == {SP_W{1'b0}}) ? STACK_DEPTH[SP_W-1:0] - 1'b1 : sp_reg - 1'b1;
    sp_inc = (sp_reg == STACK_DEPTH[SP_W-1:0] - 1'b1) ? {SP_W{1'b0}} : sp_reg + 1'b1;
    if (pop) begin
        jump = 1'b1;
        tgt  = stack_mem[sp_top];
    end
    if (wr_f && ea == `MCF_A_PCLOW) begin
        jump = 1'b1;
        tgt  = {rom_addr[11:8], res};
    end
    // status flag bits kept when the op sets flags
    keep_mask = `MCF_ST_RO_MASK | ((z_en | c_en | dig_en) ? `MCF_ST_FLAGS : 8'h00);
    st_next   = status_reg;
    if (wr_f && ea == `MCF_A_STATUS) begin
        st_next = (res & ~keep_mask) | (status_reg & keep_mask);
    end
    if (z_en) begin
        st_next[`MCF_ST_Z] = (res == 8'h00);
    end
    if (dig_en) begin
        st_next[`MCF_ST_DIG] = nib[4];
    end
    if (c_en) begin
        st_next[`MCF_ST_C] = c_val;
    end
    // interrupt taken at end of a non-branching cycle
    take   = step & ctrl_reg[`MCF_CTRL_IEN] & irq & ~iflag_reg & ~jump & ~skip;
    apb_wr = psel & penable & pready & pwrite;
end

////////////////////////////////////////////////////////////////////////////////
// Pipeline, program counter, working register and special registers.
always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        phase_two   <= `MCF_PHASE_ONE;
        rom_addr    <= `MCF_RESET_VEC;
        ir_reg      <= 14'h0000;
        flush_reg   <= 1'b1;
        w_reg       <= 8'h00;
        status_reg  <= `MCF_ST_RST;
        pointer_reg <= 8'h00;
        iflag_reg   <= 1'b0;
        iclr_reg    <= 1'b0;
        sp_reg      <= {SP_W{1'b0}};
        wplane_wr   <= 1'b0;
        wplane_addr <= 6'h00;
        wplane_data <= 8'h00;
    end else begin
        phase_two <= ~phase_two;
        wplane_wr <= wpl;
        if (wpl) begin
            wplane_addr <= fadr;
            wplane_data <= w_reg;
        end
        if (step) begin
            // latch fetched word at phase two end
            ir_reg     <= rom_data;
            flush_reg  <= jump | skip | take;
            status_reg <= st_next;
            if (take) begin
                rom_addr <= `MCF_IRQ_VEC;
            end else begin
                rom_addr <= tgt;
            end
            // push on call or entry, pop on return
            if (push || take) begin
                sp_reg <= sp_inc;
            end else if (pop) begin
                sp_reg <= sp_top;
            end
            if (wr_w) begin
                w_reg <= res;
            end
            if (wr_f && ea == `MCF_A_POINTER) begin
                pointer_reg <= res;
            end
            // interrupt flag clears one instruction after return
            if (take) begin
                iflag_reg <= 1'b1;
            end else if (exec && iclr_reg) begin
                iflag_reg <= 1'b0;
            end
            if (iret) begin
                iclr_reg <= 1'b1;
            end else if (exec) begin
                iclr_reg <= 1'b0;
            end
        end
    end
end

// six-entry return stack and general RAM.
always @(posedge ref_clk) begin
    if (step && (push || take)) begin
        stack_mem[sp_reg] <= rom_addr;
    end
    if (step && wr_f && ea >= `MCF_A_RAM_BASE) begin
        ram_mem[ea] <= res;
    end
end

////////////////////////////////////////////////////////////////////////////////
// APB slave: control writes, state reads, one wait-free access phase.
always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
        ctrl_reg <= `MCF_CTRL_RST;
        prdata   <= 32'h00000000;
        pready   <= 1'b0;
        pslverr  <= 1'b0;
    end else begin
        pready  <= psel & ~penable;
        pslverr <= 1'b0;
        if (apb_wr && paddr == `MCF_APB_CTRL) begin
            ctrl_reg <= pwdata[1:0];
        end
        if (psel && !penable) begin
            case (paddr)
                `MCF_APB_CTRL:  prdata <= {30'h00000000, ctrl_reg};
                `MCF_APB_STATE: prdata <= {15'h0000, phase_two, iflag_reg,
                                           sp_reg, rom_addr};
                `MCF_APB_WREG:  prdata <= {24'h000000, w_reg};
                `MCF_APB_FLAGS: prdata <= {24'h000000, status_reg};
                default: begin
                    prdata  <= 32'h00000000;
                    pslverr <= 1'b1;
                end
            endcase
        end
    end
end

endmodule // mcf_core

// file: pkg/mcf_defs.vh
// Constants of the microcontroller core: encodings, register map and reset values.
`ifndef MCF_DEFS_VH
`define MCF_DEFS_VH
// Instruction cycle phases.
`define MCF_PHASE_ONE  1'b0
`define MCF_PHASE_TWO  1'b1
// Program counter vectors and increment.
`define MCF_RESET_VEC  12'h000
`define MCF_IRQ_VEC    12'h001
`define MCF_PC_STEP    12'h001
// Instruction word fields.
`define MCF_CLS        13:12
`define MCF_SUBSEL     11
`define MCF_BOP        10:7
`define MCF_DBIT       6
`define MCF_FADDR      5:0
`define MCF_BITOP      10:9
`define MCF_BITNUM     8:6
`define MCF_LOP        10:8
`define MCF_LIT        7:0
`define MCF_TARGET     11:0
// Instruction classes.
`define MCF_CLS_BYTE   2'h0
`define MCF_CLS_BITLIT 2'h1
`define MCF_CLS_CALL   2'h2
`define MCF_CLS_JUMP   2'h3
// Byte-oriented operations.
`define MCF_OP_MISC    4'h0
`define MCF_OP_CLR     4'h1
`define MCF_OP_SUB     4'h2
`define MCF_OP_DEC     4'h3
`define MCF_OP_IOR     4'h4
`define MCF_OP_AND     4'h5
`define MCF_OP_XOR     4'h6
`define MCF_OP_ADD     4'h7
`define MCF_OP_MOV     4'h8
`define MCF_OP_COM     4'h9
`define MCF_OP_INC     4'ha
`define MCF_OP_RRF     4'hb
`define MCF_OP_RLF     4'hc
`define MCF_OP_SWAP    4'hd
`define MCF_OP_WPLANE  4'he
// Miscellaneous codes in the address field of the misc operation.
`define MCF_MISC_RET   6'h01
`define MCF_MISC_IRET  6'h02
// Bit operations.
`define MCF_BIT_CLR    2'h0
`define MCF_BIT_SET    2'h1
`define MCF_BIT_TSTC   2'h2
`define MCF_BIT_TSTS   2'h3
// Literal operations.
`define MCF_LOP_MOVLW  3'h0
`define MCF_LOP_RETVAL 3'h1
`define MCF_LOP_IORLW  3'h2
`define MCF_LOP_ANDLW  3'h3
`define MCF_LOP_XORLW  3'h4
`define MCF_LOP_ADDLW  3'h5
`define MCF_LOP_SUBLW  3'h6
`define MCF_LOP_RETURN 3'h7
// File plane map.
`define MCF_A_INDIRECT 6'h00
`define MCF_A_PCLOW    6'h02
`define MCF_A_STATUS   6'h03
`define MCF_A_POINTER  6'h04
`define MCF_A_RAM_BASE 6'h08
`define MCF_HALF_BIT   5
// Status register layout.
`define MCF_ST_Z       2
`define MCF_ST_DIG     1
`define MCF_ST_C       0
`define MCF_ST_RO_MASK 8'h18
`define MCF_ST_FLAGS   8'h07
`define MCF_ST_RST     8'h00
// APB register offsets and control bits.
`define MCF_APB_CTRL   12'h000
`define MCF_APB_STATE  12'h004
`define MCF_APB_WREG   12'h008
`define MCF_APB_FLAGS  12'h00c
`define MCF_CTRL_RUN   0
`define MCF_CTRL_IEN   1
`define MCF_CTRL_RST   2'h1
`endif

// file: tb/mcf_core_monitor.sv
// Port timing checker of the microcontroller core.
`timescale 1ns/1ps
module mcf_core_monitor #(
    parameter STACK_DEPTH = 6,
    parameter SP_W        = 3
) (
    input logic        ref_clk,
    input logic        nrst,
    input logic        psel,
    input logic        penable,
    input logic [11:0] paddr,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    input logic [11:0] rom_addr,
    input logic        phase_two,
    input logic        wplane_wr
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////////////
    // Phases alternate and the fetch address only moves at the end of phase two.
    a_phase_rise: assert property (!phase_two |=> phase_two)
        else $error("phase two did not follow phase one");
    a_phase_fall: assert property (phase_two |=> !phase_two)
        else $error("phase one did not follow phase two");
    a_addr_stable: assert property (!phase_two |=> $stable(rom_addr))
        else $error("fetch address moved during phase one");
    a_reset_vec: assert property ($rose(nrst) |-> rom_addr == 12'h000)
        else $error("fetch did not start at the reset vector");
    ////////////////////////////////////////////////////////////////////////////////
    // Register bus answers in one access cycle; unmapped places are refused.
    a_ready_next: assert property (psel && !penable |=> pready)
        else $error("no ready in the access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready stood longer than one cycle");
    a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error answer without ready or with data");
    a_err_unmapped: assert property (psel && penable && paddr > 12'h00c |-> pslverr)
        else $error("unmapped access not refused");
    // Write plane strobe is a single phase-one pulse.
    a_wplane_pulse: assert property (wplane_wr |=> !wplane_wr)
        else $error("write plane strobe longer than one cycle");
    a_wplane_phase: assert property (wplane_wr |-> !phase_two)
        else $error("write plane strobe outside phase one");
    c_plane: cover property (wplane_wr);
    c_refuse: cover property (pslverr);
    c_vector: cover property (rom_addr == 12'h001 && phase_two);
endmodule // mcf_core_monitor
bind mcf_core mcf_core_monitor #(.STACK_DEPTH(STACK_DEPTH), .SP_W(SP_W)) mcf_core_monitor_i (
    .ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rom_addr(rom_addr),
    .phase_two(phase_two), .wplane_wr(wplane_wr));

// file: tb/mcf_core_test.sv
// Self-checking bench of the core running small programs from the memory model.
`timescale 1ns/1ps
`define CHECK_EQ(got, exp) begin num_checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("[ERR] %0t got %h exp %h", $time, got, exp); end end
module mcf_core_test;
    typedef struct {logic [7:0] a; logic [13:0] op; logic [7:0] w; logic [2:0] f;} mcf_row_t;
    logic        ref_clk, nrst, psel, penable, pwrite, irq, pready, pslverr, e;
    logic        phase_two, wplane_wr;
    logic [11:0] paddr, rom_addr;
    logic [31:0] pwdata, prdata, v;
    logic [13:0] rom_data;
    logic [5:0]  wplane_addr, wp_a;
    logic [7:0]  wplane_data, wp_d;
    int          mismatches, num_checks, cycles, wp_n;
    // Literal loaded into W, operation word, expected W and flags zero, digit carry, carry.
    mcf_row_t    rows [9] = '{'{8'h0f, 14'h1d01, 8'h10, 3'b010},
                              '{8'hff, 14'h1d01, 8'h00, 3'b111},
                              '{8'h01, 14'h1e01, 8'h00, 3'b111},
                              '{8'h02, 14'h1e01, 8'hff, 3'b000},
                              '{8'h10, 14'h1e20, 8'h10, 3'b011},
                              '{8'h0f, 14'h1c0f, 8'h00, 3'b100},
                              '{8'hf0, 14'h1a0f, 8'hff, 3'b000},
                              '{8'h3c, 14'h1b0f, 8'h0c, 3'b000},
                              '{8'h55, 14'h0184, 8'hff, 3'b000}};
    mcf_core mcf_core_i (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rom_addr(rom_addr), .rom_data(rom_data), .irq(irq),
        .phase_two(phase_two), .wplane_wr(wplane_wr), .wplane_addr(wplane_addr),
        .wplane_data(wplane_data));
    mcf_rom mcf_rom_i (.rom_addr(rom_addr), .rom_data(rom_data));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock, hang guard and capture of write plane strobes.
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk or negedge nrst) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            give_verdict();
        end
        if (!nrst) wp_n <= 0;
        else if (wplane_wr === 1'b1) begin
            wp_n <= wp_n + 1;
            wp_a <= wplane_addr;
            wp_d <= wplane_data;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // One register bus transfer, held until ready is sampled high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // Only the bench's cycle ceiling ends a wait that never sees ready.
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd_reg(input logic [11:0] a);
        apb(1'b0, a, 32'h0, v, e);
    endtask
    // Fill memory with no-ops; the test then places its program.
    task automatic clr();
        for (int i = 0; i < 4096; i++) mcf_rom_i.mem[i] = 14'h0800;
    endtask
    // Reset for ten clocks and let the program run from the reset vector.
    task automatic boot(input int run);
        nrst <= 1'b0;
        repeat (10) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (run) @(posedge ref_clk);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {nrst, psel, penable, pwrite, irq, paddr, pwdata} = '0;
        {mismatches, num_checks, cycles} = '0;
        clr();
        repeat (5) @(posedge ref_clk);
        `CHECK_EQ(rom_addr, 12'h000)
        `CHECK_EQ(phase_two, 1'b0)
        boot(4);
        rd_reg(12'h000);
        `CHECK_EQ(v[1:0], 2'b01)
        rd_reg(12'h010);
        `CHECK_EQ({e, v}, {1'b1, 32'h0})
        // Table of arithmetic and logic cases.
        foreach (rows[i]) begin
            clr();
            mcf_rom_i.mem[0] = {6'h18, rows[i].a};
            mcf_rom_i.mem[1] = rows[i].op;
            mcf_rom_i.mem[2] = 14'h3002;
            boot(20);
            rd_reg(12'h008);
            `CHECK_EQ(v[7:0], rows[i].w)
            rd_reg(12'h00c);
            `CHECK_EQ(v[2:0], rows[i].f)
        end
        // Nested calls return in reverse order; the loop sits at 2 and 3.
        clr();
        mcf_rom_i.mem[0] = 14'h2004;
        mcf_rom_i.mem[1] = 14'h3002;
        mcf_rom_i.mem[2] = 14'h3002;
        mcf_rom_i.mem[4] = 14'h2006;
        mcf_rom_i.mem[5] = 14'h195a;
        mcf_rom_i.mem[6] = 14'h1911;
        boot(40);
        rd_reg(12'h008);
        `CHECK_EQ(v[7:0], 8'h5a)
        rd_reg(12'h004);
        `CHECK_EQ(v[14:1], 14'h0001)
        // Jump far, then write the low byte of the counter only.
        clr();
        mcf_rom_i.mem[0] = 14'h3105;
        mcf_rom_i.mem[12'h105] = 14'h1820;
        mcf_rom_i.mem[12'h106] = 14'h0042;
        mcf_rom_i.mem[12'h120] = 14'h3120;
        boot(30);
        rd_reg(12'h004);
        `CHECK_EQ(v[11:1], 11'h090)
        // Store through the pointer, read back directly, copy to the write plane.
        clr();
        mcf_rom_i.mem[0] = 14'h1810;
        mcf_rom_i.mem[1] = 14'h0044;
        mcf_rom_i.mem[2] = 14'h1899;
        mcf_rom_i.mem[3] = 14'h0040;
        mcf_rom_i.mem[4] = 14'h1800;
        mcf_rom_i.mem[5] = 14'h0410;
        mcf_rom_i.mem[6] = 14'h0715;
        mcf_rom_i.mem[7] = 14'h3007;
        boot(40);
        `CHECK_EQ({wp_n[1:0], wp_a, wp_d}, {2'h1, 6'h15, 8'h99})
        // Bit clear in the upper half is ignored; carry and digit carry survive a complement of the status register.
        clr();
        mcf_rom_i.mem[0] = 14'h18ff;
        mcf_rom_i.mem[1] = 14'h0070;
        mcf_rom_i.mem[2] = 14'h1030;
        mcf_rom_i.mem[3] = 14'h0043;
        mcf_rom_i.mem[4] = 14'h04c3;
        mcf_rom_i.mem[5] = 14'h0430;
        mcf_rom_i.mem[6] = 14'h3006;
        boot(30);
        rd_reg(12'h008);
        `CHECK_EQ(v[7:0], 8'hff)
        rd_reg(12'h00c);
        `CHECK_EQ(v[7:0], 8'h03)
        // Interrupt entry at the vector, return, and the flag clearing after it.
        clr();
        mcf_rom_i.mem[0] = 14'h3003;
        mcf_rom_i.mem[1] = 14'h1877;
        mcf_rom_i.mem[2] = 14'h0002;
        mcf_rom_i.mem[4] = 14'h3003;
        boot(4);
        apb(1'b1, 12'h000, 32'h3, v, e);
        irq <= 1'b1;
        for (int n = 0; n < 40 && v[15] !== 1'b1; n++) rd_reg(12'h004);
        irq <= 1'b0;
        `CHECK_EQ(v[15], 1'b1)
        repeat (20) @(posedge ref_clk);
        rd_reg(12'h008);
        `CHECK_EQ(v[7:0], 8'h77)
        rd_reg(12'h004);
        `CHECK_EQ(v[15:12], 4'h0)
        give_verdict();
    end
endmodule // mcf_core_test

// file: tb/mcf_rom.sv
// Program memory model: 4096 words of 14 bits, read in the same clock.
`timescale 1ns/1ps
module mcf_rom (
    input  logic [11:0] rom_addr,
    output logic [13:0] rom_data
);
    logic [13:0] mem [0:4095];
    // The addressed word is presented without delay.
    assign rom_data = mem[rom_addr];
endmodule // mcf_rom
